// ===== verilog/awc_pkg.sv
// constants and types for the extended block write command engine
package awc_pkg;
	localparam logic [7:0] OP_WR_MULT_EXT = 8'h39;
	localparam logic [7:0] OP_WR_MULT_FUA = 8'hce;
	localparam logic [3:0] RA_DATA        = 4'h0;
	localparam logic [3:0] RA_ERR         = 4'h1;
	localparam logic [3:0] RA_SCNT        = 4'h2;
	localparam logic [3:0] RA_SNUM        = 4'h3;
	localparam logic [3:0] RA_CYLL        = 4'h4;
	localparam logic [3:0] RA_CYLH        = 4'h5;
	localparam logic [3:0] RA_DEV         = 4'h6;
	localparam logic [3:0] RA_CMD         = 4'h7;
	localparam logic [3:0] RA_DCTL        = 4'h8;
	localparam int         ST_BSY         = 7;
	localparam int         ST_RDY         = 6;
	localparam int         ST_DSC         = 4;
	localparam int         ST_DRQ         = 3;
	localparam int         ST_ERR         = 0;
	localparam int         ER_UNC         = 6;
	localparam int         ER_ABT         = 2;
	localparam int         DCTL_HOB       = 7;
	localparam logic [7:0] SECTOR_WORDS_M1 = 8'hff;
	localparam logic [16:0] ZERO_COUNT_SECTORS = 17'h1_0000;
	localparam logic [7:0] ERR_RESET      = 8'h00;
	localparam logic [7:0] DCTL_RESET     = 8'h00;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} awc_host_req_t;

	typedef struct packed {
		logic [7:0] prev;
		logic [7:0] cur;
	} awc_tf_pair_t;
endpackage

// ===== verilog/awc_fifo.sv
// small word fifo between the data register and the media port
`timescale 1ns/1ns
module awc_fifo #(
	parameter int W = 16,
	parameter int D = 4
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// fill side
	input  wire logic         inValid,
	output wire logic         inReady,
	input  wire logic [W-1:0] inData,
	// drain side
	output wire logic         outValid,
	input  wire logic         outReady,
	output wire logic [W-1:0] outData,
	output wire logic         empty
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0]   count;
	wire           push = inValid && inReady;
	wire           pop  = outValid && outReady;

	assign inReady  = count != (AW+1)'(D);
	assign outValid = count != '0;
	assign empty    = !outValid;
	assign outData  = mem[rdPtr];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == AW'(D-1)) ? '0 : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == AW'(D-1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ===== verilog/awc_write_engine.sv
// task-file decoder and executor for extended block write commands
`timescale 1ns/1ns
// What this block does
// - opcode 39h starts extended block write
// - opcode CEh same, forced media commit
// - one interrupt per configured block
// - payload enters as 16-bit data words
// - count is previous:current sector-count bytes
// - zero count means 65536 sectors
// - 48-bit address from six register bytes
// - failure loads first failing address, HOB-selected
// - forced variant posts status after media commit
// - same handshaking as single-sector extended write
module awc_write_engine
	import awc_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst,
	// task-file access
	input  wire awc_host_req_t hostReq,
	output logic [15:0]        rdData,
	output logic               intrq,
	// configuration
	input  wire logic [7:0]    blockSize,
	input  wire logic          cacheOn,
	// media side
	output logic               mediaStart,
	output logic [47:0]        mediaLba,
	output logic [16:0]        mediaCount,
	output wire logic          mediaValid,
	input  wire logic          mediaReady,
	output wire logic [15:0]   mediaData,
	input  wire logic          mediaIdle,
	input  wire logic          mediaFail,
	input  wire logic [47:0]   mediaFailLba
);
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_XFER  = 4'b0010,
		S_STALL = 4'b0100,
		S_FLUSH = 4'b1000
	} awc_state_t;

	awc_state_t   state;
	awc_state_t   next_state;
	awc_tf_pair_t scnt;
	awc_tf_pair_t snum;
	awc_tf_pair_t cyll;
	awc_tf_pair_t cylh;
	logic [7:0]   devHead;
	logic [7:0]   devCtl;
	logic [7:0]   errReg;
	logic         errFlag;
	logic         fua;
	logic [16:0]  remaining;
	logic [7:0]   wordCnt;
	logic [7:0]   secInBlk;

	wire isWr      = hostReq.wr;
	wire isRd      = hostReq.rd;
	wire [3:0] ra  = hostReq.addr;
	wire hob       = devCtl[DCTL_HOB];
	wire inIdle    = state == S_IDLE;
	wire inXfer    = state == S_XFER;
	wire tfWr      = isWr && inIdle && ra >= RA_SCNT && ra <= RA_CYLH;
	wire cmdWr     = isWr && inIdle && ra == RA_CMD;
	wire opOk      = hostReq.wdata[7:0] == OP_WR_MULT_EXT || hostReq.wdata[7:0] == OP_WR_MULT_FUA;
	wire cmdGo     = cmdWr && opOk;
	wire cmdBad    = cmdWr && !opOk;
	wire [15:0] cntRaw = {scnt.prev, scnt.cur};
	wire [16:0] cntEff = (cntRaw == '0) ? ZERO_COUNT_SECTORS : {1'b0, cntRaw};
	wire [47:0] lbaIn  = {cylh.prev, cyll.prev, snum.prev, cylh.cur, cyll.cur, snum.cur};
	wire fifoInReady;
	wire fifoEmpty;
	wire wordIn    = isWr && inXfer && ra == RA_DATA;
	wire secEnd    = wordIn && wordCnt == SECTOR_WORDS_M1;
	wire lastSec   = remaining == 17'h0_0001;
	wire blkSize0  = blockSize == 8'h00;
	wire blkEnd    = secEnd && (blkSize0 || secInBlk == blockSize - 8'h01);
	wire active    = !inIdle;
	wire failNow   = active && mediaFail;
	// forced variant, or cache off, waits for media to settle before status
	wire mustWait  = fua || !cacheOn;
	wire flushOk   = !mustWait || (fifoEmpty && mediaIdle);
	wire statRd    = isRd && ra == RA_CMD;
	wire blkIrq    = blkEnd && !lastSec;
	wire doneIrq   = state == S_FLUSH && flushOk && !mediaFail;
	wire irqSet    = blkIrq || doneIrq || failNow || cmdBad;
	wire irqClr    = statRd || cmdWr;
	wire [7:0] status = {!(inIdle || inXfer), 1'b1, 1'b0, 1'b1, inXfer, 2'b00, errFlag};

	always_comb begin
		next_state = state;
		unique case (state)
			S_IDLE:  if (cmdGo) next_state = S_XFER;
			S_XFER: begin
				if (secEnd && lastSec) begin
					next_state = S_FLUSH;
				end else if (!fifoInReady) begin
					next_state = S_STALL;
				end
			end
			S_STALL: if (fifoInReady) next_state = S_XFER;
			S_FLUSH: if (flushOk) next_state = S_IDLE;
		endcase
		if (failNow) begin
			next_state = S_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// register file; count and address writes shift current byte into previous
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scnt    <= '0;
			snum    <= '0;
			cyll    <= '0;
			cylh    <= '0;
			devHead <= '0;
			devCtl  <= DCTL_RESET;
		end else begin
			if (tfWr && ra == RA_SCNT) scnt <= {scnt.cur, hostReq.wdata[7:0]};
			if (tfWr && ra == RA_SNUM) snum <= {snum.cur, hostReq.wdata[7:0]};
			if (tfWr && ra == RA_CYLL) cyll <= {cyll.cur, hostReq.wdata[7:0]};
			if (tfWr && ra == RA_CYLH) cylh <= {cylh.cur, hostReq.wdata[7:0]};
			if (isWr && inIdle && ra == RA_DEV) devHead <= hostReq.wdata[7:0];
			if (isWr && ra == RA_DCTL) devCtl <= hostReq.wdata[7:0];
			if (failNow) begin
				{cylh.prev, cyll.prev, snum.prev} <= mediaFailLba[47:24];
				{cylh.cur, cyll.cur, snum.cur}    <= mediaFailLba[23:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			errReg    <= ERR_RESET;
			errFlag   <= 1'b0;
			fua       <= 1'b0;
			remaining <= '0;
			wordCnt   <= '0;
			secInBlk  <= '0;
			intrq     <= 1'b0;
		end else begin
			intrq <= irqSet || (intrq && !irqClr);
			if (cmdWr) begin
				errReg  <= cmdBad ? (8'h01 << ER_ABT) : ERR_RESET;
				errFlag <= cmdBad;
				fua     <= hostReq.wdata[7:0] == OP_WR_MULT_FUA;
			end
			if (failNow) begin
				errReg  <= 8'h01 << ER_UNC;
				errFlag <= 1'b1;
			end
			if (cmdGo) begin
				remaining <= cntEff;
				wordCnt   <= '0;
				secInBlk  <= '0;
			end else if (wordIn) begin
				wordCnt <= wordCnt + 8'h01;
				if (secEnd) begin
					remaining <= remaining - 17'h0_0001;
					secInBlk  <= blkEnd ? 8'h00 : secInBlk + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mediaStart <= 1'b0;
			mediaLba   <= '0;
			mediaCount <= '0;
			rdData     <= '0;
		end else begin
			mediaStart <= cmdGo;
			if (cmdGo) begin
				mediaLba   <= lbaIn;
				mediaCount <= cntEff;
			end
			if (isRd) begin
				unique case (ra)
					RA_ERR:  rdData <= {8'h00, errReg};
					RA_SCNT: rdData <= {8'h00, hob ? scnt.prev : scnt.cur};
					RA_SNUM: rdData <= {8'h00, hob ? snum.prev : snum.cur};
					RA_CYLL: rdData <= {8'h00, hob ? cyll.prev : cyll.cur};
					RA_CYLH: rdData <= {8'h00, hob ? cylh.prev : cylh.cur};
					RA_DEV:  rdData <= {8'h00, devHead};
					RA_CMD:  rdData <= {8'h00, status};
					default: rdData <= '0;
				endcase
			end
		end
	end

	awc_fifo #(
		.W (16),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.inValid  (wordIn),
		.inReady  (fifoInReady),
		.inData   (hostReq.wdata),
		.outValid (mediaValid),
		.outReady (mediaReady),
		.outData  (mediaData),
		.empty    (fifoEmpty)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_op_ext;
		cmdWr && hostReq.wdata[7:0] == OP_WR_MULT_EXT |=> inXfer && !fua ##1 mediaLba == $past(lbaIn, 2);
	endproperty
	a_op_ext: assert property (p_op_ext) else $error("39h did not start a write");

	property p_op_fua;
		cmdWr && hostReq.wdata[7:0] == OP_WR_MULT_FUA |=> inXfer && fua && mediaStart;
	endproperty
	a_op_fua: assert property (p_op_fua) else $error("CEh did not start a forced write");

	property p_blk_irq;
		$rose(intrq) && active |-> $past(blkEnd) && inXfer;
	endproperty
	a_blk_irq: assert property (p_blk_irq) else $error("interrupt not on a block boundary");

	property p_word;
		wordIn && !secEnd |=> wordCnt == $past(wordCnt) + 8'h01 && !fifoEmpty;
	endproperty
	a_word: assert property (p_word) else $error("data word not taken");

	property p_count;
		cmdGo && cntRaw != '0 |=> remaining == {1'b0, $past(scnt.prev), $past(scnt.cur)};
	endproperty
	a_count: assert property (p_count) else $error("sector count assembled wrong");

	property p_zero;
		cmdGo && cntRaw == '0 |=> remaining == 17'h1_0000 ##1 mediaCount == 17'h1_0000;
	endproperty
	a_zero: assert property (p_zero) else $error("zero count not 65536");

	property p_lba;
		cmdGo |=> ##1 mediaLba[47:40] == $past(cylh.prev, 2) && mediaLba[7:0] == $past(snum.cur, 2);
	endproperty
	a_lba: assert property (p_lba) else $error("start address assembled wrong");

	property p_fail;
		failNow |=> inIdle && errFlag && errReg[ER_UNC] && snum.prev == $past(mediaFailLba[31:24]);
	endproperty
	a_fail: assert property (p_fail) else $error("failing address not loaded");

	property p_fua_wait;
		state == S_FLUSH && fua && !(fifoEmpty && mediaIdle) && !mediaFail |=> state == S_FLUSH && !$rose(intrq);
	endproperty
	a_fua_wait: assert property (p_fua_wait) else $error("forced status before media commit");

	property p_drq;
		status[ST_DRQ] |-> !status[ST_BSY] && inXfer;
	endproperty
	a_drq: assert property (p_drq) else $error("data request with busy set");

	c_multi_blk: cover property (blkIrq ##[1:1000] doneIrq);
	c_fua_done:  cover property (fua && doneIrq);
	c_fail:      cover property (failNow);
	c_stall:     cover property (state == S_STALL ##1 inXfer);
endmodule

// ===== verification/awc_host_model.sv
// host model issuing task-file register cycles
`timescale 1ns/1ns
module awc_host_model
	import awc_pkg::*;
(
	// clock
	input  wire logic        clk_sys,
	// task file
	output awc_host_req_t    hostReq,
	input  wire logic [15:0] rdData
);
	initial hostReq = '0;
	task automatic regWr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		#1 hostReq = '{1'h1, 1'h0, a, d};
		@(posedge clk_sys);
		#1 hostReq = '0;
	endtask
	task automatic regRd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		#1 hostReq = '{1'h0, 1'h1, a, 16'h0000};
		@(posedge clk_sys);
		#1 hostReq = '0;
		d = rdData;
	endtask
	// previous byte, then current
	task automatic pairWr(input logic [3:0] a, input logic [7:0] p, input logic [7:0] c);
		regWr(a, {8'h00, p});
		regWr(a, {8'h00, c});
	endtask
	// one word only after a data request
	task automatic dataWr(input logic [15:0] d, output logic ok);
		logic [15:0] s;
		ok = 1'h0;
		repeat (64) if (!ok) begin
			regRd(RA_CMD, s);
			ok = s[ST_DRQ] & ~s[ST_BSY];
		end
		if (ok)
			regWr(RA_DATA, d);
	endtask
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the extended block write engine
`timescale 1ns/1ns
module tb_top;
	import awc_pkg::*;
	logic          clk_sys = 1'h0;
	logic          rst = 1'h1;
	awc_host_req_t hostReq;
	logic [15:0]   rdData, mediaData, v;
	logic          intrq, mediaStart, mediaValid, ok;
	logic          intrqLast = 1'h0, mediaReady = 1'h0, mediaIdle = 1'h1;
	logic          mediaFail = 1'h0, cacheOn = 1'h1;
	logic [7:0]    blockSize = 8'h01;
	logic [47:0]   mediaLba, mediaFailLba = 48'h0000_0000_0000;
	logic [16:0]   mediaCount;
	logic [15:0]   wordQ[$];
	int            mismatches = 0, samplesChecked = 0;
	int            seed = 84, intCount = 0, hold = 0;

	awc_host_model i_host (.clk_sys(clk_sys), .hostReq(hostReq), .rdData(rdData));
	awc_write_engine #(.FIFO_DEPTH(4)) i_dut (.clk_sys(clk_sys), .rst(rst), .hostReq(hostReq),
		.rdData(rdData), .intrq(intrq), .blockSize(blockSize), .cacheOn(cacheOn),
		.mediaStart(mediaStart), .mediaLba(mediaLba), .mediaCount(mediaCount),
		.mediaValid(mediaValid), .mediaReady(mediaReady), .mediaData(mediaData),
		.mediaIdle(mediaIdle), .mediaFail(mediaFail), .mediaFailLba(mediaFailLba));

	always #20 clk_sys = ~clk_sys;

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// media sink: random stalls, commit stays busy a while after each word
	always @(posedge clk_sys) begin
		if (intrq === 1'h1 && !intrqLast)
			intCount++;
		intrqLast = intrq;
		hold = (hold > 0) ? hold - 1 : 0;
		if (mediaValid === 1'h1 && mediaReady) begin
			check("mediaData", mediaData, wordQ.pop_front());
			hold = 20;
		end
		#1 mediaReady = 1'($random(seed));
		mediaIdle = (hold == 0) && (mediaValid !== 1'h1);
	end

	task automatic runCmd(input logic [7:0] op, input logic [15:0] cnt, input logic [47:0] a);
		i_host.pairWr(RA_SCNT, cnt[15:8], cnt[7:0]);
		i_host.pairWr(RA_SNUM, a[31:24], a[7:0]);
		i_host.pairWr(RA_CYLL, a[39:32], a[15:8]);
		i_host.pairWr(RA_CYLH, a[47:40], a[23:16]);
		i_host.regWr(RA_CMD, {8'h00, op});
	endtask

	task automatic doXfer(input logic [7:0] op, input logic [15:0] cnt, input logic [7:0] bs);
		logic [47:0] lba;
		logic [47:0] fl;
		int          base;
		int          per;
		lba = 48'({$random(seed), $random(seed)});
		fl = 48'({$random(seed), $random(seed)});
		per = (bs == 0) ? 1 : bs;
		blockSize = bs;
		base = intCount;
		runCmd(op, cnt, lba);
		check("mediaStart", mediaStart, 1'h1);
		check("mediaLba", mediaLba, lba);
		check("mediaCount", mediaCount, (cnt == 0) ? 17'h1_0000 : 17'(cnt));
		if (cnt > 16'h0003 || cnt == 16'h0000) begin
			#40 mediaFailLba = fl;
			mediaFail = 1'h1;
			#40 mediaFail = 1'h0;
			for (int k = 0; k < 6; k++) begin
				if (k % 3 == 0)
					i_host.regWr(RA_DCTL, (k == 3) ? 16'h0080 : 16'h0000);
				i_host.regRd(4'(RA_SNUM + k % 3), v);
				check("failLba", v, {8'h00, fl[8 * k +: 8]});
			end
			i_host.regRd(RA_ERR, v);
			check("error", v, 16'h0040);
		end else begin
			for (int i = 0; i < cnt * 256; i++) begin
				v = 16'($random(seed));
				wordQ.push_back(v);
				i_host.dataWr(v, ok);
				check("dataRequest", ok, 1'h1);
			end
			v = 16'h0080;
			repeat (100) if (v[ST_BSY])
				i_host.regRd(RA_CMD, v);
			if (op == OP_WR_MULT_FUA || !cacheOn)
				check("mediaIdle", mediaIdle, 1'h1);
			check("status", v, 16'h0050);
			// cached completion may leave words in the fifo; let the sink drain them
			repeat (60) if (wordQ.size() != 0) @(posedge clk_sys);
			repeat (2) @(posedge clk_sys);
			check("interrupts", intCount - base, (cnt + per - 1) / per);
			check("wordsLeft", wordQ.size(), 0);
		end
	endtask

	initial begin
		repeat (30000) @(posedge clk_sys);
		mismatches++;
		summarize();
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		#1 rst = 1'h0;
		i_host.regRd(RA_CMD, v);
		check("status", v, 16'h0050);
		runCmd(8'h30, 16'h0001, 48'h0000_0000_0000);
		check("mediaStart", mediaStart, 1'h0);
		i_host.regRd(RA_ERR, v);
		check("error", v, 16'h0004);
		i_host.regRd(RA_CMD, v);
		check("status", v, 16'h0051);
		check("interrupts", intCount, 1);
		doXfer(OP_WR_MULT_EXT, 16'h0003, 8'h02);
		doXfer(OP_WR_MULT_FUA, 16'h0001, 8'h00);
		// cache off: plain write must also wait for the media
		cacheOn = 1'h0;
		doXfer(OP_WR_MULT_EXT, 16'h0002, 8'h01);
		cacheOn = 1'h1;
		doXfer(OP_WR_MULT_EXT, 16'h0100, 8'h10);
		doXfer(OP_WR_MULT_FUA, 16'h0000, 8'h10);
		summarize();
	end
endmodule
